/* hdl/pin_action.sv */
// Channel pin output level for compare and PWM modes
`timescale 1ns/10ps

module pin_action
  import tcsc_pkg::*;
(
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  // Configuration
  input  wire tcsc_pkg::chan_mode_t i_mode,
  input  wire logic [1:0]          i_els,
  // Counter events
  input  wire logic                i_match,
  input  wire logic                i_count_down,
  input  wire logic                i_period_start,
  // Pin level
  output logic                     o_level
);

  logic level_r;
  logic level_nxt;
  logic low_true;

  assign low_true = i_els[0];
  assign o_level  = level_r;

  // ==========================================
  // Next level
  always_comb
  begin
    level_nxt = level_r;
    unique case (i_mode)
      MODE_CAPTURE:
      begin
        level_nxt = level_r;
      end
      MODE_COMPARE:
      begin
        if (i_match)
        begin
          unique case (i_els)
            ELS_RELEASE: level_nxt = level_r;
            ELS_RISE:    level_nxt = ~level_r;
            ELS_FALL:    level_nxt = 1'b0;
            ELS_BOTH:    level_nxt = 1'b1;
          endcase
        end
      end
      MODE_EDGE_PWM:
      begin
        if (i_match)
          level_nxt = low_true;
        else if (i_period_start)
          level_nxt = ~low_true;
      end
      MODE_CENTER_PWM:
      begin
        if (i_match && !i_count_down)
          level_nxt = low_true;
        else if (i_match && i_count_down)
          level_nxt = ~low_true;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      level_r <= 1'b0;
    else
      level_r <= level_nxt;
  end

endmodule

/* hdl/timer_channel_status_control.sv */
// Status and control logic for one timer channel
`timescale 1ns/10ps

// Function
// - Capture mode: active pin edge sets flag
// - Compare or edge PWM: counter match sets flag
// - Center PWM: every match sets flag
// - Interrupt while flag and enable set
// - Clear flag by read then write zero
// - New event restarts the clear sequence
// - Writing one ignored; reset clears flag, enable
// - Interrupt enable is plain read/write bit
// - Mode high bit selects edge PWM
// - Mode low bit: capture or compare
// - Select 00 releases pin from timer
// - Capture edge: rising, falling or both
// - Compare action: none, toggle, low, high
// - Edge PWM: 10 high-true, X1 low-true
// - Center PWM polarity set at up-match
// - Center select forces center PWM channel
// - Status/control write resets coherency latch
module timer_channel_status_control
  import tcsc_pkg::*;
#(
  parameter int ADDR_W = 2,
  parameter int CNT_W  = 16
)
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // Register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [7:0]             o_rdata,
  // Timer module side
  input  wire logic              i_center_pwm_select,
  input  wire logic [CNT_W-1:0]  i_counter,
  input  wire logic [CNT_W-1:0]  i_value,
  input  wire logic              i_count_step,
  input  wire logic              i_count_down,
  input  wire logic              i_period_start,
  output logic                   o_capture,
  output logic                   o_latch_reset,
  output tcsc_pkg::chan_mode_t   o_mode,
  // Channel pin
  input  wire logic              i_pin,
  output logic                   o_pin,
  output logic                   o_pin_oe,
  output logic                   o_pin_release,
  // Interrupt
  output logic                   o_irq
);

  // ==========================================
  // Elaboration checks
  if (ADDR_W < 2)
  begin : g_bad_addr
    $error("ADDR_W must be at least 2");
  end
  if (CNT_W < 1)
  begin : g_bad_cnt
    $error("CNT_W must be at least 1");
  end
  if (IRQ_BITS > 8)
  begin : g_bad_irq
    $error("IRQ_BITS must fit in one byte");
  end

  // ==========================================
  // State
  logic                event_flag_r;
  logic                event_flag_nxt;
  logic                clear_armed_r;
  logic                clear_armed_nxt;
  logic                irq_enable_r;
  logic [1:0]          mode_sel_r;
  logic [1:0]          els_r;
  logic                pin_prev_r;
  logic [IRQ_BITS-1:0] irq_status_r;
  logic [IRQ_BITS-1:0] irq_status_nxt;
  logic [IRQ_BITS-1:0] irq_mask_r;
  logic [7:0]          rdata_r;
  logic                capture_r;
  logic                latch_reset_r;

  // ==========================================
  // Address decode
  wire logic sel_sc    = (i_addr == ADDR_W'(OFS_STATUS_CONTROL));
  wire logic sel_stat  = (i_addr == ADDR_W'(OFS_IRQ_STATUS));
  wire logic sel_mask  = (i_addr == ADDR_W'(OFS_IRQ_MASK));
  wire logic wr_sc     = i_wr & sel_sc;
  wire logic rd_sc     = i_rd & sel_sc;
  wire logic wr_stat   = i_wr & sel_stat;
  wire logic wr_mask   = i_wr & sel_mask;

  // ==========================================
  // Mode decode
  chan_mode_t mode;
  always_comb
  begin
    if (i_center_pwm_select)
      mode = MODE_CENTER_PWM;
    else if (mode_sel_r[1])
      mode = MODE_EDGE_PWM;
    else if (mode_sel_r[0])
      mode = MODE_COMPARE;
    else
      mode = MODE_CAPTURE;
  end
  assign o_mode = mode;

  // ==========================================
  // Event detection
  // pin released
  wire logic released   = (els_r == ELS_RELEASE);
  wire logic is_capture = (mode == MODE_CAPTURE);
  wire logic rise       = i_pin & ~pin_prev_r;
  wire logic fall       = ~i_pin & pin_prev_r;

  wire logic edge_hit   = (els_r[0] & rise) | (els_r[1] & fall);
  wire logic cap_event  = is_capture & ~released & edge_hit;

  wire logic cnt_equal  = (i_counter == i_value);
  wire logic match_ev   = ~is_capture & i_count_step & cnt_equal;
  wire logic chan_event = cap_event | match_ev;

  // ==========================================
  // Event flag clearing sequence
  wire logic wr_flag_zero = wr_sc & ~i_wdata[BIT_EVENT_FLAG];

  always_comb
  begin
    event_flag_nxt  = event_flag_r;
    clear_armed_nxt = clear_armed_r;
    if (rd_sc && event_flag_r)
      clear_armed_nxt = 1'b1;
    if (wr_flag_zero && clear_armed_r)
      event_flag_nxt = 1'b0;
    if (wr_sc)
      clear_armed_nxt = 1'b0;
    if (chan_event)
    begin
      event_flag_nxt  = 1'b1;
      clear_armed_nxt = 1'b0;
    end
  end

  // ==========================================
  // Sticky interrupt status
  wire logic [IRQ_BITS-1:0] irq_set = {match_ev, cap_event};
  wire logic [IRQ_BITS-1:0] irq_clr = wr_stat ? i_wdata[IRQ_BITS-1:0] : '0;

  // Set wins over a clearing write
  for (genvar b = 0; b < IRQ_BITS; b++)
  begin : g_irq_bit
    assign irq_status_nxt[b] = irq_set[b] | (irq_status_r[b] & ~irq_clr[b]);
  end

  // ==========================================
  // Read data mux
  wire logic [7:0] sc_value = {event_flag_r, irq_enable_r, mode_sel_r, els_r, 2'b00};
  wire logic [7:0] rd_mux   =
    sel_sc   ? sc_value :
    sel_stat ? {{(8-IRQ_BITS){1'b0}}, irq_status_r} :
    sel_mask ? {{(8-IRQ_BITS){1'b0}}, irq_mask_r} :
    8'h00;

  // ==========================================
  // Registers
  // flag and arming
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      event_flag_r  <= RST_STATUS_CONTROL[BIT_EVENT_FLAG];
      clear_armed_r <= 1'b0;
    end
    else
    begin
      event_flag_r  <= event_flag_nxt;
      clear_armed_r <= clear_armed_nxt;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      irq_enable_r <= RST_STATUS_CONTROL[BIT_IRQ_ENABLE];
    else if (wr_sc)
      irq_enable_r <= i_wdata[BIT_IRQ_ENABLE];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      mode_sel_r <= RST_STATUS_CONTROL[BIT_MODE_HIGH:BIT_MODE_LOW];
      els_r      <= RST_STATUS_CONTROL[BIT_ELS_HIGH:BIT_ELS_LOW];
    end
    else if (wr_sc)
    begin
      mode_sel_r <= i_wdata[BIT_MODE_HIGH:BIT_MODE_LOW];
      els_r      <= i_wdata[BIT_ELS_HIGH:BIT_ELS_LOW];
    end
  end

  // Sticky status
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      irq_status_r <= RST_IRQ;
    else
      irq_status_r <= irq_status_nxt;
  end

  // Status mask
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      irq_mask_r <= RST_IRQ;
    else if (wr_mask)
      irq_mask_r <= i_wdata[IRQ_BITS-1:0];
  end

  // Read data stands one cycle
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      rdata_r <= 8'h00;
    else
      rdata_r <= i_rd ? rd_mux : 8'h00;
  end

  // Pin history for edge detection
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      pin_prev_r <= 1'b0;
    else
      pin_prev_r <= i_pin;
  end

  // Capture strobe to value datapath
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      capture_r <= 1'b0;
    else
      capture_r <= cap_event;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      latch_reset_r <= 1'b0;
    else
      latch_reset_r <= wr_sc;
  end

  assign o_rdata       = rdata_r;
  assign o_capture     = capture_r;
  assign o_latch_reset = latch_reset_r;

  // ==========================================
  // Pin control
  logic level;

  pin_action u_pin_action
  (
    .i_clk          (i_clk),
    .i_sys_rst      (i_sys_rst),
    .i_mode         (mode),
    .i_els          (els_r),
    .i_match        (match_ev),
    .i_count_down   (i_count_down),
    .i_period_start (i_period_start),
    .o_level        (level)
  );

  assign o_pin_release = released;
  assign o_pin_oe      = ~released & ~is_capture;
  assign o_pin         = level;

  // ==========================================
  // Interrupt
  // flag and enable, or sticky status under mask
  assign o_irq = (event_flag_r & irq_enable_r) | (|(irq_status_r & irq_mask_r));

endmodule

/* shared/tcsc_pkg.sv */
// Constants and types for the timer channel status/control block
package tcsc_pkg;

  // ==========================================
  // Register offsets (word index on the plain port)
  localparam logic [1:0] OFS_STATUS_CONTROL = 2'h0;
  localparam logic [1:0] OFS_IRQ_STATUS     = 2'h1;
  localparam logic [1:0] OFS_IRQ_MASK       = 2'h2;

  // ==========================================
  // Field positions in the status/control byte
  localparam int BIT_EVENT_FLAG  = 7;
  localparam int BIT_IRQ_ENABLE  = 6;
  localparam int BIT_MODE_HIGH   = 5;
  localparam int BIT_MODE_LOW    = 4;
  localparam int BIT_ELS_HIGH    = 3;
  localparam int BIT_ELS_LOW     = 2;

  // Sticky interrupt status bits
  localparam int BIT_ST_CAPTURE  = 0;
  localparam int BIT_ST_MATCH    = 1;
  localparam int IRQ_BITS        = 2;

  // ==========================================
  // Reset values
  localparam logic [7:0] RST_STATUS_CONTROL = 8'h00;
  localparam logic [1:0] RST_IRQ            = 2'h0;

  // ==========================================
  // Edge/level select codes
  localparam logic [1:0] ELS_RELEASE = 2'h0;
  localparam logic [1:0] ELS_RISE    = 2'h1;
  localparam logic [1:0] ELS_FALL    = 2'h2;
  localparam logic [1:0] ELS_BOTH    = 2'h3;

  // ==========================================
  // Channel operating modes
  typedef enum logic [1:0] {
    MODE_CAPTURE    = 2'b00,
    MODE_COMPARE    = 2'b01,
    MODE_EDGE_PWM   = 2'b10,
    MODE_CENTER_PWM = 2'b11
  } chan_mode_t;

endpackage

/* testbench/ext_pin_model.sv */
// Behavioural model of the outside signal source on the channel pin
`timescale 1ns/10ps

module ext_pin_model
(
  // Source and pin
  input  wire logic i_drv,
  input  wire logic i_oe,
  input  wire logic i_out,
  output logic      o_level
);
  assign o_level = i_oe ? i_out : i_drv;
endmodule

/* testbench/tcsc_props.sv */
// Port-level assertions for the timer channel status/control block
`timescale 1ns/10ps

module tcsc_props
  import tcsc_pkg::*;
#(
  parameter int ADDR_W = 2,
  parameter int CNT_W  = 16
)
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  // Register port
  input  wire logic [ADDR_W-1:0]    i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic                 i_wr,
  // Channel side
  input  wire logic                 i_center_pwm_select,
  input  wire logic                 o_capture,
  input  wire logic                 o_latch_reset,
  input  wire tcsc_pkg::chan_mode_t o_mode,
  input  wire logic                 o_pin_oe,
  input  wire logic                 o_pin_release,
  input  wire logic                 o_irq
);
  // ==========================================
  // Status/control write decode
  wire sc_wr;
  assign sc_wr = i_wr && i_addr == ADDR_W'(OFS_STATUS_CONTROL);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // ==========================================
  // Properties
  property p_latch_set; sc_wr |=> o_latch_reset; endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch reset missing");
  property p_latch_src; o_latch_reset |-> $past(sc_wr); endproperty
  a_latch_src: assert property (p_latch_src) else $error("stray latch reset");
  property p_release; sc_wr && i_wdata[3:2] == 2'h0 |=> o_pin_release; endproperty
  a_release: assert property (p_release) else $error("pin not released");
  property p_oe; o_pin_oe |-> !o_pin_release && o_mode != MODE_CAPTURE; endproperty
  a_oe: assert property (p_oe) else $error("pin driven wrongly");
  property p_center; i_center_pwm_select |-> o_mode == MODE_CENTER_PWM; endproperty
  a_center: assert property (p_center) else $error("center mode not forced");
  property p_edge;
    (sc_wr && i_wdata[5]) ##1 !i_center_pwm_select |-> o_mode == MODE_EDGE_PWM;
  endproperty
  a_edge: assert property (p_edge) else $error("edge pwm not selected");
  property p_cmp;
    (sc_wr && i_wdata[5:4] == 2'h1) ##1 !i_center_pwm_select |-> o_mode == MODE_COMPARE;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare not selected");
  property p_cap; o_capture |-> $past(o_mode) == MODE_CAPTURE; endproperty
  a_cap: assert property (p_cap) else $error("capture outside capture mode");
  property p_rst; $fell(i_sys_rst) |-> !o_irq && o_pin_release && !o_capture; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule

bind timer_channel_status_control tcsc_props #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) tcsc_props_i (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_center_pwm_select(i_center_pwm_select), .o_capture(o_capture),
  .o_latch_reset(o_latch_reset), .o_mode(o_mode), .o_pin_oe(o_pin_oe),
  .o_pin_release(o_pin_release), .o_irq(o_irq));

/* testbench/timer_channel_status_control_tb_top.sv */
// Self-checking bench for the timer channel status/control block
`timescale 1ns/10ps

module timer_channel_status_control_tb_top;
  import tcsc_pkg::*;
  // ==========================================
  // Signals and expected-value table
  logic        i_clk, i_sys_rst, i_wr, i_rd, cps, step, down, pstart, ext_lvl, pin_lvl;
  logic        o_pin, o_pin_oe, o_pin_release, o_irq, cap;
  logic [1:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata;
  logic [15:0] cnt, val;
  chan_mode_t  o_mode;
  int          fail_count, num_checks;
  int          cap_cnt = 0;
  // Byte, center select, event kind, expected pin
  logic [19:0] tbl [12] = '{20'h1c001, 20'h18000, 20'h14001, 20'h14000, 20'h28000, 20'h28021,
                            20'h24001, 20'h24020, 20'h08100, 20'h08111, 20'h04101, 20'h04110};

  timer_channel_status_control timer_channel_status_control_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_center_pwm_select(cps), .i_counter(cnt),
    .i_value(val), .i_count_step(step), .i_count_down(down), .i_period_start(pstart),
    .o_capture(cap), .o_latch_reset(), .o_mode(o_mode), .i_pin(pin_lvl), .o_pin(o_pin),
    .o_pin_oe(o_pin_oe), .o_pin_release(o_pin_release), .o_irq(o_irq));
  ext_pin_model ext_pin_model_i (.i_drv(ext_lvl), .i_oe(o_pin_oe), .i_out(o_pin),
    .o_level(pin_lvl));

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Count capture strobes
  always @(posedge i_clk)
    if (cap === 1'b1)
      cap_cnt <= cap_cnt + 1;

  // ==========================================
  // Tasks
  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task pin(input logic v);
    @(posedge i_clk);
    ext_lvl <= v;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task ev(input logic [3:0] k);
    logic [15:0] v;
    v = 16'($urandom);
    @(posedge i_clk);
    cnt <= v;
    val <= v;
    step <= k < 4'h2;
    down <= k[0];
    pstart <= k == 4'h2;
    @(posedge i_clk);
    step <= 1'b0;
    pstart <= 1'b0;
    #1;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    finish_test();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    {i_sys_rst, i_wr, i_rd, cps, step, down, pstart, ext_lvl} = 8'h80;
    {i_addr, i_wdata, cnt, val} = '0;
    void'($urandom(24981));
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(0, 8'h00);
    wr(3, 8'hff);
    rd(3, 8'h00);
    for (int e = 1; e < 4; e++)
    begin
      wr(0, 8'(e << 2));
      pin(1'b1);
      rd(0, {e[0], 3'h0, e[1:0], 2'h0});
      wr(0, 8'(e << 2));
      pin(1'b0);
      rd(0, {e[1], 3'h0, e[1:0], 2'h0});
      wr(0, 8'(e << 2));
    end
    pin(1'b1);
    wr(0, 8'h8c);
    wr(0, 8'h0c);
    rd(0, 8'h8c);
    pin(1'b0);
    wr(0, 8'h0c);
    rd(0, 8'h8c);
    wr(0, 8'h4c);
    rd(0, 8'h4c);
    chk({7'h0, o_irq}, 8'h00);
    pin(1'b1);
    chk({7'h0, o_irq}, 8'h01);
    wr(2, 8'h01);
    rd(1, 8'h01);
    rd(0, 8'hcc);
    wr(0, 8'h0c);
    chk({7'h0, o_irq}, 8'h01);
    wr(1, 8'h01);
    chk({7'h0, o_irq}, 8'h00);
    foreach (tbl[i])
    begin
      @(posedge i_clk) cps <= tbl[i][8];
      wr(0, tbl[i][19:12]);
      ev(tbl[i][7:4]);
      chk({7'h0, pin_lvl}, {7'h0, tbl[i][0]});
    end
    rd(0, 8'h84);
    wr(0, 8'h04);
    wr(0, 8'h10);
    // leave center PWM without passing through capture
    @(posedge i_clk) cps <= 1'b0;
    ev(4'h0);
    rd(0, 8'h90);
    chk({6'h0, o_pin_oe, o_pin_release}, 8'h01);
    rd(1, 8'h02);
    chk(8'(cap_cnt), 8'h07);
    finish_test();
  end
endmodule
